// ==== inc/enc_meas_pkg.sv ====
package enc_meas_pkg;

  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_NS = 10;
  localparam logic [31:0] TICK_STEP = 32'(CLK_PERIOD_NS / TICK_NS);
  localparam int INTERP_MIN_PERIOD_NS = 1340;
  localparam logic [31:0] INTERP_MIN_TICKS =
    32'(INTERP_MIN_PERIOD_NS / TICK_NS);

  localparam int DIV_WIDTH = 48;
  localparam int FRAC_BITS = 8;
  localparam logic [7:0] FRAC_MAX = 8'hFF;
  localparam logic [7:0] FRAC_ZERO = 8'h00;

  localparam logic [15:0] DUTY_FULL = 16'h2710;
  localparam logic [15:0] DUTY_VALUE_RESET = 16'h0000;
  localparam logic [15:0] DUTY_MIN_RESET = 16'h2710;
  localparam logic [15:0] DUTY_MAX_RESET = 16'h0000;
  localparam logic [15:0] DUTY_CLEARED = 16'h0000;

  localparam logic [15:0] CMD_CLR_MIN_CH1 = 16'h9130;
  localparam logic [15:0] CMD_CLR_MAX_CH1 = 16'h9140;
  localparam logic [15:0] CMD_CLR_MIN_CH2 = 16'h9131;
  localparam logic [15:0] CMD_CLR_MAX_CH2 = 16'h9141;

  localparam int PIN_A = 0;
  localparam int PIN_B = 1;
  localparam int PIN_C = 2;
  localparam int PIN_LATCH = 3;
  localparam int PIN_GATE = 4;
  localparam int PIN_COUNT = 5;
  localparam logic [2:0] SYNC_SETTLE = 3'h4;

  typedef enum logic [1:0] {
    EVAL_FOURFOLD = 2'h0,
    EVAL_ONEFOLD = 2'h1,
    EVAL_TWOFOLD = 2'h2
  } eval_mode_t;

  typedef struct packed {
    logic interpEnable;
    eval_mode_t evalMode;
    logic zeroLatchEnable;
    logic latchRiseEnable;
    logic latchFallEnable;
    logic latch2RiseEnable;
    logic latch2FallEnable;
    logic compactStamp;
  } chan_config_t;

  typedef struct packed {
    logic start;
    logic [DIV_WIDTH-1:0] num;
    logic [DIV_WIDTH-1:0] den;
  } div_req_t;

  typedef struct packed {
    logic [PIN_COUNT-1:0] pinSync1;
    logic [PIN_COUNT-1:0] pinSync2;
    logic [PIN_COUNT-1:0] pinSync3;
    logic [PIN_COUNT-1:0] pinLevel;
    logic [2:0] settle;
    logic [31:0] tick;
    logic [31:0] riseTick;
    logic [31:0] fallTick;
    logic haveRise;
    logic haveFall;
    div_req_t dutyReq;
    logic [15:0] latestDuty;
    logic dutyFresh;
    logic [15:0] dutyValue;
    logic [15:0] dutyMin;
    logic [15:0] dutyMax;
    logic [31:0] countTick;
    logic [31:0] countPeriod;
    logic haveCount;
    logic countSeq;
    logic interpTag;
    div_req_t interpReq;
    logic interpStall;
    logic [7:0] frac;
    logic [63:0] lastCountStamp;
    logic [31:0] counterValue;
    logic [63:0] countStamp;
    logic [63:0] zeroStamp;
    logic [63:0] latchStamp;
    logic [63:0] latch2Stamp;
    logic [31:0] latchValue;
    logic [31:0] latch2Value;
  } meas_state_t;

endpackage

// ==== hdl/duty_divider.sv ====
`timescale 1ns/10ps
module duty_divider #(
  parameter int WIDTH = 48
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic start,
  input wire logic [WIDTH-1:0] numerator,
  input wire logic [WIDTH-1:0] denominator,
  output logic busy,
  output logic done,
  output logic [WIDTH-1:0] quotient
);

  localparam int CW = $clog2(WIDTH + 1);
  localparam logic [CW-1:0] STEPS = CW'(WIDTH);
  localparam logic [CW-1:0] LAST = CW'(1);

  typedef struct packed {
    logic [WIDTH-1:0] quo;
    logic [WIDTH-1:0] rem;
    logic [WIDTH-1:0] den;
    logic [CW-1:0] cnt;
    logic busy;
    logic done;
  } div_state_t;

  div_state_t s;
  div_state_t next_s;

  // Restoring division, one bit per cycle; zero divisor gives all ones
  always_comb begin
    logic [WIDTH:0] trial;
    logic bitOut;
    trial = '0;
    bitOut = 1'b0;
    next_s = s;
    next_s.done = 1'b0;
    if (!s.busy) begin
      if (start) begin
        next_s.quo = numerator;
        next_s.rem = '0;
        next_s.den = denominator;
        next_s.cnt = STEPS;
        next_s.busy = 1'b1;
      end
    end else begin
      trial = {s.rem, s.quo[WIDTH-1]};
      if (trial >= {1'b0, s.den}) begin
        bitOut = 1'b1;
        next_s.rem = WIDTH'(trial - {1'b0, s.den});
      end else begin
        next_s.rem = trial[WIDTH-1:0];
      end
      next_s.quo = {s.quo[WIDTH-2:0], bitOut};
      next_s.cnt = s.cnt - LAST;
      if (s.cnt == LAST) begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign busy = s.busy;
  assign done = s.done;
  assign quotient = s.quo;

endmodule // duty_divider

// ==== hdl/encoder_duty_interp_timestamp.sv ====
`timescale 1ns/10ps
module encoder_duty_interp_timestamp #(
  parameter int CHANNEL = 0
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic trackA,
  input wire logic trackB,
  input wire logic trackC,
  input wire logic latchIn,
  input wire logic gateIn,
  input wire enc_meas_pkg::chan_config_t cfg,
  input wire logic cycleStrobe,
  input wire logic cmdValid,
  input wire logic [15:0] cmdWord,
  input wire logic [31:0] baseCount,
  input wire logic [63:0] dcTime,
  output logic [15:0] dutyValue,
  output logic [15:0] dutyMin,
  output logic [15:0] dutyMax,
  output logic [31:0] counterValue,
  output logic interpStall,
  output logic [63:0] countStamp,
  output logic [63:0] zeroStamp,
  output logic [63:0] latchStamp,
  output logic [63:0] latch2Stamp,
  output logic [31:0] latchValue,
  output logic [31:0] latch2Value
);

  localparam int W = enc_meas_pkg::DIV_WIDTH;

  enc_meas_pkg::meas_state_t s;
  enc_meas_pkg::meas_state_t next_s;

  logic dutyBusy;
  logic dutyDone;
  logic [W-1:0] dutyQuot;
  logic interpBusy;
  logic interpDone;
  logic [W-1:0] interpQuot;

  // Which edges of A and B count, per evaluation mode
  function automatic logic isCountEdge(
    input enc_meas_pkg::eval_mode_t mode,
    input logic [enc_meas_pkg::PIN_COUNT-1:0] rise,
    input logic [enc_meas_pkg::PIN_COUNT-1:0] fall
  );
    logic hit;
    hit = 1'b0;
    case (mode)
      enc_meas_pkg::EVAL_ONEFOLD: begin
        hit = rise[enc_meas_pkg::PIN_A];
      end
      enc_meas_pkg::EVAL_TWOFOLD: begin
        hit = rise[enc_meas_pkg::PIN_A] | fall[enc_meas_pkg::PIN_A];
      end
      // Unused code 3 falls back to fourfold
      default: begin
        hit = rise[enc_meas_pkg::PIN_A] | fall[enc_meas_pkg::PIN_A] |
          rise[enc_meas_pkg::PIN_B] | fall[enc_meas_pkg::PIN_B];
      end
    endcase
    return hit;
  endfunction

  // Compact form keeps only the low word of system time
  function automatic logic [63:0] pickStamp(
    input logic compact,
    input logic [63:0] stamp
  );
    logic [63:0] outStamp;
    outStamp = stamp;
    if (compact) begin
      outStamp = {32'h0000_0000, stamp[31:0]};
    end
    return outStamp;
  endfunction

  // Clear codes depend on which channel this instance is
  function automatic logic isClearMin(input logic [15:0] word);
    logic hit;
    hit = (CHANNEL == 0) ? (word == enc_meas_pkg::CMD_CLR_MIN_CH1)
                         : (word == enc_meas_pkg::CMD_CLR_MIN_CH2);
    return hit;
  endfunction

  function automatic logic isClearMax(input logic [15:0] word);
    logic hit;
    hit = (CHANNEL == 0) ? (word == enc_meas_pkg::CMD_CLR_MAX_CH1)
                         : (word == enc_meas_pkg::CMD_CLR_MAX_CH2);
    return hit;
  endfunction

  duty_divider #(
    .WIDTH(W)
  ) dutyDiv (
    .clock(clock),
    .rst(rst),
    .start(s.dutyReq.start),
    .numerator(s.dutyReq.num),
    .denominator(s.dutyReq.den),
    .busy(dutyBusy),
    .done(dutyDone),
    .quotient(dutyQuot)
  );

  duty_divider #(
    .WIDTH(W)
  ) interpDiv (
    .clock(clock),
    .rst(rst),
    .start(s.interpReq.start),
    .numerator(s.interpReq.num),
    .denominator(s.interpReq.den),
    .busy(interpBusy),
    .done(interpDone),
    .quotient(interpQuot)
  );

  always_comb begin
    logic [enc_meas_pkg::PIN_COUNT-1:0] pins;
    logic [enc_meas_pkg::PIN_COUNT-1:0] rise;
    logic [enc_meas_pkg::PIN_COUNT-1:0] fall;
    logic countEdge;
    logic [31:0] elapsed;
    logic [31:0] period;
    logic [15:0] dutyResult;
    logic latchHit;
    logic latch2Hit;
    pins = {gateIn, latchIn, trackC, trackB, trackA};
    rise = '0;
    fall = '0;
    countEdge = 1'b0;
    elapsed = '0;
    period = '0;
    dutyResult = '0;
    latchHit = 1'b0;
    latch2Hit = 1'b0;
    next_s = s;
    next_s.dutyReq.start = 1'b0;
    next_s.interpReq.start = 1'b0;

    // Three-stage sync, level moves only when stages two and three agree
    next_s.pinSync1 = pins;
    next_s.pinSync2 = s.pinSync1;
    next_s.pinSync3 = s.pinSync2;
    for (int i = 0; i < enc_meas_pkg::PIN_COUNT; i++) begin
      if (s.pinSync2[i] == s.pinSync3[i]) begin
        next_s.pinLevel[i] = s.pinSync3[i];
      end
    end
    rise = next_s.pinLevel & ~s.pinLevel;
    fall = ~next_s.pinLevel & s.pinLevel;
    // First agreed level after reset is idle, not an edge
    if (s.settle != enc_meas_pkg::SYNC_SETTLE) begin
      next_s.settle = s.settle + 3'h1;
      rise = '0;
      fall = '0;
    end

    next_s.tick = s.tick + enc_meas_pkg::TICK_STEP;

    if (rise[enc_meas_pkg::PIN_A]) begin
      next_s.riseTick = s.tick;
      next_s.haveRise = 1'b1;
      next_s.haveFall = 1'b0;
      // scale on-time by full scale, then divide
      if (s.haveRise && s.haveFall && !dutyBusy && !s.dutyReq.start) begin
        next_s.dutyReq.start = 1'b1;
        next_s.dutyReq.num = W'(W'(s.fallTick - s.riseTick) *
          W'(enc_meas_pkg::DUTY_FULL));
        next_s.dutyReq.den = W'(s.tick - s.riseTick);
      end
    end
    // on-time ends at the fall after a rise
    if (fall[enc_meas_pkg::PIN_A] && s.haveRise) begin
      next_s.fallTick = s.tick;
      next_s.haveFall = 1'b1;
    end

    // clear by command for this channel
    // second channel decodes its own codes
    if (cmdValid && isClearMin(cmdWord)) begin
      next_s.dutyMin = enc_meas_pkg::DUTY_CLEARED;
    end
    if (cmdValid && isClearMax(cmdWord)) begin
      next_s.dutyMax = enc_meas_pkg::DUTY_CLEARED;
    end

    if (dutyDone) begin
      dutyResult = (dutyQuot > W'(enc_meas_pkg::DUTY_FULL)) ?
        enc_meas_pkg::DUTY_FULL : dutyQuot[15:0];
      next_s.latestDuty = dutyResult;
      next_s.dutyFresh = 1'b1;
      // a clear sets 0, so min stays 0 after it; a new value beats a clear for max only
      if (dutyResult < next_s.dutyMin) begin
        next_s.dutyMin = dutyResult;
      end
      if (dutyResult > next_s.dutyMax) begin
        next_s.dutyMax = dutyResult;
      end
    end

    // count edge chosen by evaluation mode
    countEdge = isCountEdge(cfg.evalMode, rise, fall);
    elapsed = s.tick - s.countTick;
    period = s.tick - s.countTick;
    if (countEdge) begin
      next_s.lastCountStamp = dcTime;
      next_s.countPeriod = period;
      next_s.countTick = s.tick;
      next_s.haveCount = 1'b1;
      next_s.countSeq = ~s.countSeq;
      next_s.frac = enc_meas_pkg::FRAC_ZERO;
      // too short a period for interpolation
      next_s.interpStall = s.haveCount &&
        (period <= enc_meas_pkg::INTERP_MIN_TICKS);
    end else if (cfg.interpEnable && s.haveCount && !interpBusy &&
                 !s.interpReq.start) begin
      // fraction is elapsed time over last count period
      next_s.interpReq.start = 1'b1;
      next_s.interpReq.num = W'({elapsed, enc_meas_pkg::FRAC_ZERO});
      next_s.interpReq.den = W'(s.countPeriod);
      next_s.interpTag = s.countSeq;
    end
    // Results begun before the latest count edge are stale
    if (interpDone && !countEdge && (s.interpTag == s.countSeq)) begin
      next_s.frac = (interpQuot > W'(enc_meas_pkg::FRAC_MAX)) ?
        enc_meas_pkg::FRAC_MAX : interpQuot[enc_meas_pkg::FRAC_BITS-1:0];
    end

    // latch the process image once per host cycle
    if (cycleStrobe) begin
      if (next_s.dutyFresh) begin
        next_s.dutyValue = next_s.latestDuty;
      end
      next_s.dutyFresh = 1'b0;
      next_s.countStamp = pickStamp(cfg.compactStamp,
        next_s.lastCountStamp);
      if (cfg.interpEnable) begin
        next_s.counterValue = {baseCount[31-enc_meas_pkg::FRAC_BITS:0],
          next_s.interpStall ? enc_meas_pkg::FRAC_ZERO : next_s.frac};
      end else begin
        next_s.counterValue = baseCount;
      end
    end

    // zero pulse rise captures count and time
    if (rise[enc_meas_pkg::PIN_C] && cfg.zeroLatchEnable) begin
      next_s.latchValue = baseCount;
      next_s.zeroStamp = pickStamp(cfg.compactStamp, dcTime);
    end
    // latch input on its enabled edge
    latchHit = (rise[enc_meas_pkg::PIN_LATCH] && cfg.latchRiseEnable) ||
      (fall[enc_meas_pkg::PIN_LATCH] && cfg.latchFallEnable);
    if (latchHit) begin
      next_s.latchValue = baseCount;
      next_s.latchStamp = pickStamp(cfg.compactStamp, dcTime);
    end
    latch2Hit = (rise[enc_meas_pkg::PIN_GATE] && cfg.latch2RiseEnable) ||
      (fall[enc_meas_pkg::PIN_GATE] && cfg.latch2FallEnable);
    if (latch2Hit) begin
      next_s.latch2Value = baseCount;
      next_s.latch2Stamp = pickStamp(cfg.compactStamp, dcTime);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s <= '0;
      s.dutyValue <= enc_meas_pkg::DUTY_VALUE_RESET;
      s.dutyMin <= enc_meas_pkg::DUTY_MIN_RESET;
      s.dutyMax <= enc_meas_pkg::DUTY_MAX_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign dutyValue = s.dutyValue;
  assign dutyMin = s.dutyMin;
  assign dutyMax = s.dutyMax;
  assign counterValue = s.counterValue;
  assign interpStall = s.interpStall;
  assign countStamp = s.countStamp;
  assign zeroStamp = s.zeroStamp;
  assign latchStamp = s.latchStamp;
  assign latch2Stamp = s.latch2Stamp;
  assign latchValue = s.latchValue;
  assign latch2Value = s.latch2Value;

endmodule // encoder_duty_interp_timestamp

// ==== verification/encoder_checker.sv ====
`timescale 1ns/10ps
module encoder_checker #(
  parameter int CHANNEL = 0
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic latchIn,
  input wire logic gateIn,
  input wire enc_meas_pkg::chan_config_t cfg,
  input wire logic cycleStrobe,
  input wire logic cmdValid,
  input wire logic [15:0] cmdWord,
  input wire logic [31:0] baseCount,
  input wire logic [15:0] dutyValue,
  input wire logic [15:0] dutyMin,
  input wire logic [15:0] dutyMax,
  input wire logic [31:0] counterValue,
  input wire logic interpStall,
  input wire logic [63:0] countStamp,
  input wire logic [63:0] latchStamp,
  input wire logic [63:0] latch2Stamp
);
  localparam logic [15:0] MIN_CODE = (CHANNEL == 0) ?
    enc_meas_pkg::CMD_CLR_MIN_CH1 : enc_meas_pkg::CMD_CLR_MIN_CH2;
  logic [31:0] prevBase;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Held past the pin filter
  sequence latchRise;
    !latchIn ##1 latchIn [*4];
  endsequence
  sequence gateFall;
    gateIn ##1 !gateIn [*4];
  endsequence
  always_ff @(posedge clock) begin
    prevBase <= baseCount;
  end
  a_reset_values: assert property (
    $fell(rst) |-> dutyMin == 16'h2710 && dutyMax == 16'h0000)
    else $error("limits wrong after reset");
  a_duty_hold: assert property (
    !cycleStrobe |=> $stable(dutyValue))
    else $error("duty moved without strobe");
  a_min_clear: assert property (
    cmdValid && cmdWord == MIN_CODE |=> dutyMin == 16'h0000)
    else $error("minimum not cleared");
  a_plain_count: assert property (
    cycleStrobe && !cfg.interpEnable |=> counterValue == prevBase)
    else $error("plain count wrong");
  a_frac_place: assert property (
    cycleStrobe && cfg.interpEnable
      |=> counterValue[31:8] == prevBase[23:0])
    else $error("count not shifted");
  a_stall_frac: assert property (
    cycleStrobe && cfg.interpEnable && interpStall
      |=> counterValue[7:0] == 8'h00)
    else $error("fraction not zero");
  a_compact_stamp: assert property (
    cycleStrobe && cfg.compactStamp |=> countStamp[63:32] == 32'h0)
    else $error("compact stamp high word");
  a_latch_stamp: assert property (
    latchRise ##0 cfg.latchRiseEnable |-> ##[1:3] $changed(latchStamp))
    else $error("latch not stamped");
  a_gate_stamp: assert property (
    gateFall ##0 cfg.latch2FallEnable |-> ##[1:3] $changed(latch2Stamp))
    else $error("gate not stamped");
endmodule // encoder_checker

bind encoder_duty_interp_timestamp encoder_checker #(.CHANNEL(CHANNEL))
  u_chk (.clock(clock), .rst(rst), .latchIn(latchIn), .gateIn(gateIn),
  .cfg(cfg), .cycleStrobe(cycleStrobe), .cmdValid(cmdValid),
  .cmdWord(cmdWord), .baseCount(baseCount), .dutyValue(dutyValue),
  .dutyMin(dutyMin), .dutyMax(dutyMax), .counterValue(counterValue),
  .interpStall(interpStall), .countStamp(countStamp),
  .latchStamp(latchStamp), .latch2Stamp(latch2Stamp));

// ==== verification/encoder_model.sv ====
`timescale 1ns/10ps
module encoder_model (
  input wire logic clock,
  input wire logic run,
  input wire logic [15:0] period,
  input wire logic [15:0] onTime,
  output logic trackA,
  output logic trackB,
  output logic trackC
);
  logic [15:0] phase = 16'h0000;
  initial begin
    trackA = 1'b0;
    trackB = 1'b0;
    trackC = 1'b0;
  end
  // Stopped shaft freezes all tracks
  always @(posedge clock) begin
    if (run) begin
      phase <= (phase + 16'h0001 >= period) ? 16'h0000 : phase + 16'h0001;
    end
    trackA <= phase < onTime;
    trackB <= phase >= (period >> 2) && phase < (period >> 2) + (period >> 1);
    // Four clocks wide, enough for the filter
    trackC <= phase < 16'h0004;
  end
endmodule // encoder_model

// ==== verification/testbench.sv ====
`timescale 1ns/10ps
module testbench;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic latchIn = 1'b0;
  logic gateIn = 1'b1;
  logic cycleStrobe = 1'b0;
  logic cmdValid = 1'b0;
  logic [15:0] cmdWord = 16'h0000;
  logic [31:0] baseCount = 32'h1234_5678;
  logic [63:0] dcTime = 64'h1_0000_0000;
  enc_meas_pkg::chan_config_t cfg = '0;
  logic run = 1'b0;
  logic [15:0] period = 16'h0064;
  logic [15:0] onTime = 16'h0019;
  logic trackA;
  logic trackB;
  logic trackC;
  logic [15:0] dutyValue;
  logic [15:0] dutyMin;
  logic [15:0] dutyMax;
  logic [31:0] counterValue;
  logic interpStall;
  logic [63:0] countStamp;
  logic [63:0] zeroStamp;
  logic [63:0] latchStamp;
  logic [63:0] latch2Stamp;
  logic [31:0] latchValue;
  logic [31:0] latch2Value;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;

  always #10 clock = ~clock;
  always @(negedge clock) dcTime <= dcTime + 64'h14;

  encoder_model u_encoder_model (.clock(clock), .run(run), .period(period),
    .onTime(onTime), .trackA(trackA), .trackB(trackB), .trackC(trackC));

  encoder_duty_interp_timestamp #(.CHANNEL(0))
    u_encoder_duty_interp_timestamp (.clock(clock), .rst(rst),
    .trackA(trackA), .trackB(trackB), .trackC(trackC), .latchIn(latchIn),
    .gateIn(gateIn), .cfg(cfg), .cycleStrobe(cycleStrobe),
    .cmdValid(cmdValid), .cmdWord(cmdWord), .baseCount(baseCount),
    .dcTime(dcTime), .dutyValue(dutyValue), .dutyMin(dutyMin),
    .dutyMax(dutyMax), .counterValue(counterValue),
    .interpStall(interpStall), .countStamp(countStamp),
    .zeroStamp(zeroStamp), .latchStamp(latchStamp),
    .latch2Stamp(latch2Stamp), .latchValue(latchValue),
    .latch2Value(latch2Value));

  task complete_run;
    if (fail_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask

  // Run far longer than the planned scenarios
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      complete_run();
    end
  end

  task strobe;
    cycleStrobe = 1'b1;
    @(negedge clock);
    cycleStrobe = 1'b0;
    @(negedge clock);
  endtask

  task send_cmd(input logic [15:0] code);
    cmdWord = code;
    cmdValid = 1'b1;
    @(negedge clock);
    cmdValid = 1'b0;
    @(negedge clock);
  endtask

  task duty_case(input logic [15:0] per, input logic [15:0] on,
    input logic [15:0] exp);
    period = per;
    onTime = on;
    run = 1'b1;
    repeat (800) @(negedge clock);
    strobe();
    check(dutyValue, exp);
    check(counterValue, baseCount);
  endtask

  task automatic clear_case;
    logic [15:0] codes [4] = '{16'h9131, 16'h9141, 16'h9130, 16'h9140};
    logic [15:0] expMin [4] = '{16'h09C4, 16'h09C4, 16'h0000, 16'h0000};
    logic [15:0] expMax [4] = '{16'h1D4C, 16'h1D4C, 16'h1D4C, 16'h0000};
    run = 1'b0;
    repeat (100) @(negedge clock);
    for (int i = 0; i < 4; i++) begin
      send_cmd(codes[i]);
      check(dutyMin, expMin[i]);
      check(dutyMax, expMax[i]);
    end
  endtask

  task stall_case(input logic [1:0] mode, input logic [15:0] per,
    input logic expStall);
    cfg.evalMode = enc_meas_pkg::eval_mode_t'(mode);
    cfg.interpEnable = 1'b1;
    period = per;
    onTime = per >> 1;
    run = 1'b1;
    repeat (8 * per) @(negedge clock);
    strobe();
    check(interpStall, expStall);
    check(counterValue[31:8], baseCount[23:0]);
    if (expStall) begin
      check(counterValue[7:0], 8'h00);
    end
  endtask

  task stamp_case;
    logic [63:0] s;
    run = 1'b0;
    // Stopped shaft lets the fraction saturate
    repeat (200) @(negedge clock);
    strobe();
    s = countStamp;
    check(counterValue, {baseCount[23:0], 8'hFF});
    check(s[63:32], 32'h0000_0001);
    strobe();
    check(countStamp, s);
    cfg.compactStamp = 1'b1;
    strobe();
    check(countStamp, {32'h0000_0000, s[31:0]});
  endtask

  task latch_case;
    logic [63:0] t;
    cfg.latchRiseEnable = 1'b1;
    cfg.latch2FallEnable = 1'b1;
    baseCount = 32'h00AB_CDEF;
    repeat (4) @(negedge clock);
    latchIn = 1'b1;
    gateIn = 1'b0;
    // Stamp lands on the fourth edge; compact mode still set
    repeat (4) @(posedge clock);
    t = {32'h0000_0000, dcTime[31:0]};
    @(negedge clock);
    check(latchStamp, t);
    check(latchValue, baseCount);
    check(latch2Stamp, t);
    check(latch2Value, baseCount);
    latchIn = 1'b0;
    repeat (10) @(negedge clock);
    check(latchStamp, t);
  endtask

  initial begin
    cfg.zeroLatchEnable = 1'b1;
    repeat (6) @(negedge clock);
    rst = 1'b0;
    repeat (4) @(negedge clock);
    check(dutyValue, 16'h0000);
    check(dutyMin, 16'h2710);
    check(dutyMax, 16'h0000);
    duty_case(16'h0064, 16'h0019, 16'h09C4);
    duty_case(16'h0064, 16'h004B, 16'h1D4C);
    check(latchValue, baseCount);
    check(zeroStamp[63:32], 32'h0000_0001);
    clear_case();
    stall_case(2'h0, 16'h0190, 1'b0);
    stall_case(2'h0, 16'h0064, 1'b1);
    stall_case(2'h2, 16'h0064, 1'b1);
    stall_case(2'h1, 16'h0043, 1'b1);
    stall_case(2'h1, 16'h0044, 1'b0);
    stamp_case();
    latch_case();
    complete_run();
  end
endmodule // testbench
